// [pkg/cwo_regs.svh]
// Constants for the configuration word and oscillator setup block
`ifndef CWO_REGS_SVH
`define CWO_REGS_SVH
// ==========================================================
// Configuration word layout
`define CWO_CFG_W          12
`define CWO_CFG_IMPL_W     5
`define CWO_BIT_RST_FUNC   4
`define CWO_BIT_CP_N       3
`define CWO_BIT_WDT_EN     2
`define CWO_BIT_PULLUP_N   1
`define CWO_BIT_FREQ_SEL   0
`define CWO_CFG_ERASED     12'h01F
// ==========================================================
// Oscillator trim register
`define CWO_TRIM_ADDR      8'h05
`define CWO_TRIM_RESET     8'hFE
// ==========================================================
// Program memory
`define CWO_PC_W           8
`define CWO_PC_LAST        8'hFF
`define CWO_PC_START       8'h00
`define CWO_LOAD_OP        4'hC
// ==========================================================
// Timing
`define CWO_CLK_HZ         125000000
`define CWO_DRT_NS         1125000
`define CWO_DRT_W          18
// Divider ticks for 4 and 8 MHz at 125 MHz clock
`define CWO_DIV_4M         8'd31
`define CWO_DIV_8M         8'd16
`define CWO_WDT_DIV        16'd4095
`define CWO_WDT_W          16
`endif

// [pkg/cwo_pkg.sv]
// Types shared by the configuration word and oscillator setup block
package cwo_pkg;
   typedef struct packed {
      logic       reset_pin_function_select;
      logic       code_protect_n;
      logic       watchdog_enable;
      logic       reset_pin_pullup_n;
      logic       osc_freq_select;
   } cwo_cfg_type;

   typedef struct packed {
      logic       wr;
      logic [11:0] data;
   } cwo_prog_type;

   typedef enum logic [3:0] {
      CWO_ST_POR  = 4'h1,
      CWO_ST_DRT  = 4'h2,
      CWO_ST_VEC  = 4'h4,
      CWO_ST_RUN  = 4'h8
   } cwo_state_type;
endpackage : cwo_pkg

// [rtl/cwo_wdt.sv]
// Watchdog timer on its own free running tick
`timescale 1ns/100ps
`include "cwo_regs.svh"
module cwo_wdt (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic enable,
   input  wire logic clear,
   output logic      timeout
);
   logic [`CWO_WDT_W-1:0] rc_div;
   logic                  rc_tick;
   logic [7:0]            count;

   // ==========================================================
   // Dedicated RC tick, not derived from the system clock select
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rc_div <= '0;
         rc_tick <= 1'b0;
      end else begin
         rc_tick <= (rc_div == `CWO_WDT_DIV);
         rc_div <= (rc_div == `CWO_WDT_DIV) ? '0 : rc_div + 1'b1;
      end
   end

   // ==========================================================
   // Counter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
         timeout <= 1'b0;
      end else if (!enable || clear) begin
         count <= '0;
         timeout <= 1'b0;
      end else begin
         timeout <= rc_tick && (count == 8'hFF);
         if (rc_tick) begin
            count <= count + 8'h01;
         end
      end
   end
endmodule : cwo_wdt

// [rtl/cwo_core.sv]
// Configuration word, reset sequencing and oscillator trim
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "cwo_regs.svh"
// How it works
// - Twelve-bit word, bits eleven to five zero
// - Bit four picks master clear or I/O
// - Bit three low turns code protection on
// - Bit two alone enables the watchdog
// - Watchdog runs from its own tick
// - Bit one low enables pull-up, if master clear
// - Bit zero selects 8 or 4 MHz
// - Program cannot read or write the word
// - Internal oscillator is the only clock source
// - Reset starts at last address, loads literal
// - Calibration word always readable
// - Writing trim register at 05h trims oscillator
// - Reset timer delays only on power-up
// - Pin change or watchdog wakes from sleep
module cwo_core (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         power_up,
   input  wire logic         prog_mode,
   input  wire logic         prog_wr,
   input  wire logic [11:0]  prog_wdata,
   output logic [11:0]       prog_rdata,
   input  wire logic         prog_rd_cal,
   output logic [7:0]        prog_cal_rdata,
   input  wire logic [7:0]   cal_value,
   input  wire logic [7:0]   addr,
   input  wire logic [7:0]   wdata,
   input  wire logic         wr,
   input  wire logic         rd,
   output logic [7:0]        rdata,
   input  wire logic [7:0]   prog_mem_addr,
   output logic [7:0]        prog_mem_fetch_ok,
   input  wire logic         pin_in,
   output logic              pin_out,
   output logic              pin_oe,
   input  wire logic         pin_drive,
   input  wire logic         pin_drive_en,
   input  wire logic         master_clear_input_n,
   input  wire logic         sleep_req,
   input  wire logic         wdt_clear,
   input  wire logic [3:0]   pin_states,
   output logic              cpu_reset,
   output logic              sleeping,
   output logic              wake,
   output logic              wdt_reset,
   output logic [7:0]        pc,
   output logic [7:0]        working,
   output logic [7:0]        osc_trim_register,
   output logic              osc_tick,
   output logic              reset_pin_pullup_on,
   output logic              code_protected,
   output logic              watchdog_running,
   output logic              internal_oscillator_mode
);
   localparam longint DRT_CYC_L = (longint'(`CWO_DRT_NS) * `CWO_CLK_HZ) / 1000000000;
   parameter int unsigned DRT_CYCLES = int'(DRT_CYC_L);

   logic [11:0]             nv_word;
   cwo_pkg::cwo_cfg_type    cfg;
   cwo_pkg::cwo_state_type  state;
   logic [`CWO_DRT_W-1:0]   drt_cnt;
   logic                    por_pending;
   logic [7:0]              osc_div;
   logic [3:0]              pin_last;
   logic                    wdt_timeout;
   logic                    master_clear_input_active;
   logic                    osc_wrap;

   function automatic logic [7:0] cwo_div_end(input logic sel);
      cwo_div_end = sel ? `CWO_DIV_8M : `CWO_DIV_4M;
   endfunction : cwo_div_end

   // ==========================================================
   // Non-volatile word, external programming path only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         nv_word <= `CWO_CFG_ERASED;
      end else if (prog_mode && prog_wr) begin
         nv_word <= {7'h00, prog_wdata[`CWO_CFG_IMPL_W-1:0]};
      end
   end
   assign prog_rdata = prog_mode ? nv_word : 12'h000;
   // Calibration value stays readable whatever the protection bit says
   assign prog_cal_rdata = prog_mode ? cal_value : 8'h00;

   // ==========================================================
   // Latch the word while held in reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= '0;
      end else if (state != cwo_pkg::CWO_ST_RUN) begin
         cfg <= nv_word[`CWO_CFG_IMPL_W-1:0];
      end
   end

   assign master_clear_input_active = cfg.reset_pin_function_select && !master_clear_input_n;
   assign pin_oe = !cfg.reset_pin_function_select && pin_drive_en;
   assign pin_out = pin_drive;
   assign reset_pin_pullup_on = cfg.reset_pin_function_select
                                && !cfg.reset_pin_pullup_n;
   assign code_protected = !cfg.code_protect_n;
   assign watchdog_running = cfg.watchdog_enable;
   assign internal_oscillator_mode = 1'b1;
   // Last word is always fetchable; others blocked to the programmer when protected
   assign prog_mem_fetch_ok = (!prog_mode || cfg.code_protect_n
                               || prog_mem_addr == `CWO_PC_LAST) ? 8'h01 : 8'h00;

   // ==========================================================
   // Reset sequencing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= cwo_pkg::CWO_ST_POR;
         drt_cnt <= '0;
         por_pending <= 1'b1;
      end else begin
         case (state)
            cwo_pkg::CWO_ST_POR: begin
               drt_cnt <= '0;
               if (!master_clear_input_active && !power_up) begin
                  state <= por_pending ? cwo_pkg::CWO_ST_DRT : cwo_pkg::CWO_ST_VEC;
               end
            end
            cwo_pkg::CWO_ST_DRT: begin
               if (master_clear_input_active) begin
                  state <= cwo_pkg::CWO_ST_POR;
               end else if (drt_cnt == `CWO_DRT_W'(DRT_CYCLES - 1)) begin
                  por_pending <= 1'b0;
                  state <= cwo_pkg::CWO_ST_VEC;
               end else begin
                  drt_cnt <= drt_cnt + 1'b1;
               end
            end
            cwo_pkg::CWO_ST_VEC: begin
               state <= cwo_pkg::CWO_ST_RUN;
            end
            cwo_pkg::CWO_ST_RUN: begin
               if (master_clear_input_active || wdt_reset) begin
                  state <= cwo_pkg::CWO_ST_POR;
               end
            end
            default: begin
               state <= cwo_pkg::CWO_ST_POR;
            end
         endcase
      end
   end
   assign cpu_reset = (state != cwo_pkg::CWO_ST_RUN);

   // ==========================================================
   // Reset vector: execute the load literal, then wrap to zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc <= `CWO_PC_LAST;
         working <= '0;
      end else if (state == cwo_pkg::CWO_ST_VEC) begin
         working <= cal_value;
         pc <= `CWO_PC_START;
      end else if (state != cwo_pkg::CWO_ST_RUN) begin
         pc <= `CWO_PC_LAST;
      end else if (!sleeping) begin
         pc <= pc + 8'h01;
      end
   end

   // ==========================================================
   // Trim register, unchanged by later resets
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_trim_register <= `CWO_TRIM_RESET;
      end else if (wr && state == cwo_pkg::CWO_ST_RUN && addr == `CWO_TRIM_ADDR) begin
         osc_trim_register <= wdata;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata <= '0;
      end else begin
         // The configuration word has no data address here
         rdata <= (rd && addr == `CWO_TRIM_ADDR) ? osc_trim_register : 8'h00;
      end
   end

   // ==========================================================
   // Instruction clock enable; trim nudges the divide end
   // Wrap one count early so the period is exactly the divide end, one cycle tick
   assign osc_wrap = (osc_div >= cwo_div_end(cfg.osc_freq_select)
                      + {7'h00, osc_trim_register[7]} - 8'h01);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_div <= '0;
         osc_tick <= 1'b0;
      end else begin
         osc_tick <= osc_wrap;
         osc_div <= osc_wrap ? 8'h00 : osc_div + 8'h01;
      end
   end

   // ==========================================================
   // Sleep and wake
   cwo_wdt u_wdt (
      .clk     (clk),
      .sys_rst (sys_rst),
      .enable  (cfg.watchdog_enable && state == cwo_pkg::CWO_ST_RUN),
      .clear   (wdt_clear),
      .timeout (wdt_timeout)
   );
   assign wdt_reset = wdt_timeout && !sleeping;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sleeping <= 1'b0;
         wake <= 1'b0;
         pin_last <= '0;
      end else begin
         pin_last <= pin_states;
         wake <= 1'b0;
         if (state != cwo_pkg::CWO_ST_RUN) begin
            sleeping <= 1'b0;
         end else if (sleeping && (pin_states != pin_last || wdt_timeout)) begin
            sleeping <= 1'b0;
            wake <= 1'b1;
         end else if (sleep_req) begin
            sleeping <= 1'b1;
         end
      end
   end
endmodule : cwo_core

// [sim/cwo_core_props.sv]
// Assertions on the configuration word and oscillator setup block
`timescale 1ns/100ps
module cwo_core_props #(
   parameter int unsigned DRT_CYCLES = 20
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        prog_mode,
   input wire logic [11:0] prog_rdata,
   input wire logic [7:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic [7:0]  prog_mem_addr,
   input wire logic [7:0]  prog_mem_fetch_ok,
   input wire logic        pin_oe,
   input wire logic [7:0]  cal_value,
   input wire logic        code_protected,
   input wire logic        cpu_reset,
   input wire logic        sleeping,
   input wire logic        wake,
   input wire logic [3:0]  pin_states,
   input wire logic [7:0]  working,
   input wire logic [7:0]  osc_trim_register,
   input wire logic        reset_pin_pullup_on,
   input wire logic        internal_oscillator_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========
   // Sequences
   // Two quiet cycles rule out the vector cycle, where trim writes are ignored
   sequence trim_wr_s;
      wr && addr == 8'h05 && !cpu_reset && $past(!cpu_reset);
   endsequence
   sequence trim_rd_s;
      rd && addr == 8'h05;
   endsequence
   a_upper_bits_zero: assert property (prog_rdata[11:5] == 7'h00)
      else $error("config upper bits not zero");
   a_word_hidden: assert property (!prog_mode |-> prog_rdata == 12'h000)
      else $error("config word visible outside programming");
   a_unmapped_zero: assert property (rd && addr != 8'h05 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_pullup_io_off: assert property (pin_oe |-> !reset_pin_pullup_on)
      else $error("pull-up on while pin is I/O");
   a_protect_blocks: assert property (code_protected && prog_mode && prog_mem_addr != 8'hFF
      |-> prog_mem_fetch_ok == 8'h00) else $error("protected fetch allowed");
   a_cal_readable: assert property (prog_mem_addr == 8'hFF |-> prog_mem_fetch_ok == 8'h01)
      else $error("calibration word not readable");
   a_osc_mode_only: assert property (internal_oscillator_mode == 1'b1)
      else $error("oscillator mode not internal");
   a_trim_write: assert property (trim_wr_s |=> osc_trim_register == $past(wdata))
      else $error("trim write lost");
   a_trim_read: assert property (trim_rd_s |=> rdata == $past(osc_trim_register))
      else $error("trim read wrong");
   a_vector_load: assert property ($fell(cpu_reset) |-> ##[0:1] working == cal_value)
      else $error("working not loaded with calibration");
   a_pin_wake: assert property (sleeping && $changed(pin_states) |-> ##[0:2] wake)
      else $error("no wake on pin change");
endmodule : cwo_core_props
bind cwo_core cwo_core_props #(.DRT_CYCLES(DRT_CYCLES)) cwo_core_props_inst (.clk, .sys_rst,
   .prog_mode, .prog_rdata, .addr, .wdata, .wr, .rd, .rdata, .prog_mem_addr, .prog_mem_fetch_ok,
   .pin_oe, .cal_value, .code_protected, .cpu_reset, .sleeping, .wake, .pin_states, .working,
   .osc_trim_register, .reset_pin_pullup_on, .internal_oscillator_mode);

// [sim/cwo_prog_model.sv]
// Programmer model that saves the calibration and writes the word
`timescale 1ns/100ps
module cwo_prog_model (
   input  wire logic        clk,
   input  wire logic [11:0] prog_rdata,
   input  wire logic [7:0]  prog_cal_rdata,
   output logic             prog_mode,
   output logic             prog_wr,
   output logic             prog_rd_cal,
   output logic [11:0]      prog_wdata
);
   logic [7:0]  saved_cal;
   logic [11:0] read_word;
   initial begin
      prog_mode = 1'b0;
      prog_wr = 1'b0;
      prog_rd_cal = 1'b0;
      prog_wdata = 12'hA5A;
   end
   task automatic program_word(input logic [11:0] w);
      @(posedge clk);
      prog_mode <= 1'b1;
      prog_rd_cal <= 1'b1;
      @(posedge clk);
      saved_cal = prog_cal_rdata;
      prog_rd_cal <= 1'b0;
      prog_wr <= 1'b1;
      prog_wdata <= w;
      @(posedge clk);
      prog_wr <= 1'b0;
      prog_wdata <= ~w;
      @(posedge clk);
      read_word = prog_rdata;
      prog_mode <= 1'b0;
   endtask : program_word
endmodule : cwo_prog_model

// [sim/cwo_core_tb.sv]
// Self-checking bench for the configuration word and oscillator setup block
`timescale 1ns/100ps
module cwo_core_tb;
   localparam int         DEVICE_RESET_TIMER = 20;
   localparam logic [7:0] CAL = 8'h5C;
   logic clk, sys_rst, power_up, wr, rd, pin_drive, pin_drive_en, master_clear_input_n;
   logic sleep_req, prog_mode, prog_wr, prog_rd_cal, pin_out, pin_oe, cpu_reset, sleeping;
   logic wake, wdt_reset, osc_tick, reset_pin_pullup_on, code_protected, watchdog_running;
   logic internal_oscillator_mode;
   logic [7:0]  addr, wdata, rdata, prog_mem_addr, prog_mem_fetch_ok, pc, working;
   logic [7:0]  osc_trim_register, prog_cal_rdata;
   logic [3:0]  pin_states;
   logic [11:0] prog_rdata, prog_wdata;
   logic [4:0]  w;
   logic [4:0]  words [3] = '{5'h1E, 5'h11, 5'h0D};
   int          n_errors = 0, compares = 0, n, lim;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   cwo_core #(.DRT_CYCLES(DEVICE_RESET_TIMER)) cwo_core_inst (.clk, .sys_rst, .power_up, .prog_mode, .prog_wr,
      .prog_wdata, .prog_rdata, .prog_rd_cal, .prog_cal_rdata, .cal_value(CAL), .addr, .wdata,
      .wr, .rd, .rdata, .prog_mem_addr, .prog_mem_fetch_ok, .pin_in(1'b0), .pin_out, .pin_oe,
      .pin_drive, .pin_drive_en, .master_clear_input_n, .sleep_req, .wdt_clear(1'b0),
      .pin_states, .cpu_reset, .sleeping, .wake, .wdt_reset, .pc, .working, .osc_trim_register,
      .osc_tick, .reset_pin_pullup_on, .code_protected, .watchdog_running,
      .internal_oscillator_mode);
   cwo_prog_model cwo_prog_model_inst (.clk, .prog_rdata, .prog_cal_rdata, .prog_mode, .prog_wr,
      .prog_rd_cal, .prog_wdata);
   // ==========
   // Tasks
   task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(nm, {4'h0, rdata}, {4'h0, e});
   endtask : bus_rd
   // Counts cycles held in reset, bounded so a stuck reset cannot hang the run
   task automatic wait_run();
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (cpu_reset !== 1'b0 && n < 1000);
   endtask : wait_run
   task automatic print_verdict();
      $display("Compares %0d, errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   initial begin
      #(8 * 20000);
      n_errors++;
      print_verdict();
   end
   // ==========
   // Tests
   initial begin
      {sys_rst, power_up, wr, rd, sleep_req, pin_drive, pin_drive_en} = 7'b1000011;
      {addr, wdata, prog_mem_addr, pin_states, master_clear_input_n} = 29'h1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      wait_run();
      chk("cold delay", n >= DEVICE_RESET_TIMER, 1);
      chk("working", working, CAL);
      chk("hidden", prog_rdata, 12'h000);
      chk("osc mode", internal_oscillator_mode, 1);
      bus_rd(8'h05, 8'hFE, "trim reset");
      bus_rd(8'h00, 8'h00, "unmapped");
      @(posedge clk);
      addr <= 8'h05;
      wdata <= 8'h5A;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      bus_rd(8'h05, 8'h5A, "trim write");
      for (int i = 0; i < 3; i++) begin
         w = words[i];
         cwo_prog_model_inst.program_word({7'h7F, w});
         chk("word", cwo_prog_model_inst.read_word, {7'h00, w});
         chk("cal saved", cwo_prog_model_inst.saved_cal, CAL);
         chk("held", code_protected, i == 2 ? 1'b1 : 1'b0);
         master_clear_input_n <= 1'b0;
         @(posedge clk);
         master_clear_input_n <= 1'b1;
         wait_run();
         chk("warm delay", n < DEVICE_RESET_TIMER, 1);
         chk("protect", code_protected, !w[3]);
         chk("watchdog", watchdog_running, w[2]);
         chk("pullup", reset_pin_pullup_on, w[4] & !w[1]);
         chk("pin oe", pin_oe, !w[4]);
         chk("working", working, CAL);
         bus_rd(8'h05, 8'h5A, "trim kept");
         prog_mem_addr <= 8'hFF;
         @(posedge clk);
         #1 chk("cal fetch", prog_mem_fetch_ok, 1);
         prog_mem_addr <= 8'h00;
         @(posedge clk);
         #1 chk("fetch", prog_mem_fetch_ok, 1);
         lim = w[0] ? 31 : 16;
         n = 0;
         repeat (496) begin
            @(posedge clk);
            if (osc_tick === 1'b1) n++;
         end
         chk("osc rate", n >= lim - 1 && n <= lim + 1, 1);
      end
      master_clear_input_n <= 1'b0;
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
      @(posedge clk);
      #1 chk("pin ignored", cpu_reset, 0);
      chk("sleeping", sleeping, 1);
      pin_states <= 4'h1;
      n = 0;
      repeat (4) begin
         @(posedge clk);
         if (wake === 1'b1) n++;
      end
      chk("wake", n, 1);
      print_verdict();
   end
endmodule : cwo_core_tb
